// [logic/scg_pkg.sv]
package scg_pkg;

	// Register byte offsets on the APB
	localparam logic [7:0] SYS_CFG_OFS  = 8'h00;
	localparam logic [7:0] PLL_CFG_OFS  = 8'h04;
	localparam logic [7:0] PRESC_OFS    = 8'h08;
	localparam logic [7:0] STATUS_OFS   = 8'h0C;

	// Field widths
	localparam int SEL_W   = 2;
	localparam int BAND_W  = 2;
	localparam int PLL_INPUT_DIV_FIELD_W  = 4;
	localparam int PLL_MULT_FIELD_W  = 8;
	localparam int PLL_OUTPUT_DIV_FIELD_W = 7;
	localparam int PRESCALER_DIV_FIELD_W = 10;
	localparam int PER_W   = 20;
	localparam int ACC_W   = 21;

	// Field positions in pll_config_reg
	localparam int PLL_BYP_POS  = 0;
	localparam int PLL_REF_POS  = 1;
	localparam int PLL_BAND_LSB = 2;
	localparam int PLL_PLL_INPUT_DIV_FIELD_LSB = 4;
	localparam int PLL_PLL_MULT_FIELD_LSB = 8;
	localparam int PLL_K2_LSB   = 16;

	// Field positions in the status register
	localparam int ST_ACT_LSB  = 0;
	localparam int ST_LOCK_POS = 2;
	localparam int ST_SW_POS   = 3;
	localparam int ST_EN_POS   = 4;

	// Source select codes
	localparam logic [1:0] SEL_WAKEUP = 2'h0;
	localparam logic [1:0] SEL_RSVD   = 2'h1;
	localparam logic [1:0] SEL_OSC    = 2'h2;
	localparam logic [1:0] SEL_DIRECT = 2'h3;

	// VCO band codes
	localparam logic [1:0] BAND_LOW  = 2'h0;
	localparam logic [1:0] BAND_MID  = 2'h1;
	localparam logic [1:0] BAND_HIGH = 2'h2;

	// Indices into the vector of sampled clock inputs
	localparam int IN_DIRECT = 0;
	localparam int IN_XTAL   = 1;
	localparam int IN_INTOSC = 2;
	localparam int IN_WAKEUP = 3;
	localparam int IN_N      = 4;

	// Reset values
	localparam logic [1:0]         SEL_RST   = 2'h0;
	localparam logic [PRESCALER_DIV_FIELD_W-1:0] PRESCALER_DIV_FIELD_RST = 10'h000;

	typedef enum logic [1:0] {
		SRC_WAKEUP = 2'h0,
		SRC_PRESC  = 2'h1,
		SRC_PLL    = 2'h2,
		SRC_DIRECT = 2'h3
	} scg_src_t;

	typedef struct packed {
		logic [PLL_OUTPUT_DIV_FIELD_W-1:0] pll_output_div_field;
		logic [PLL_MULT_FIELD_W-1:0]  pll_mult_field;
		logic [PLL_INPUT_DIV_FIELD_W-1:0]  pll_input_div_field;
		logic [BAND_W-1:0]  band;
		logic               ref_sel;
		logic               bypass;
	} scg_pll_cfg_t;

	localparam scg_pll_cfg_t PLL_CFG_RST = '{pll_output_div_field: 7'h00, pll_mult_field: 8'h00, pll_input_div_field: 4'h0,
		band: 2'h0, ref_sel: 1'b0, bypass: 1'b1};

endpackage : scg_pkg

// [logic/scg_clock_gen.sv]
// Behaviour
// RL1: Select 11 passes the direct clock pin through unchanged to the system clock.
// RL2: Select 10 with bypass 1 divides oscillator or internal source by prescaler field plus one.
// RL3: Prescaler divides by up to 1024 at the maximum field value.
// RL4: Prescaler factor one passes the oscillator clock with its own duty cycle.
// RL5: Select 10 with bypass 0 enables the PLL and uses its output.
// RL6: PLL output equals input times N over P times K2, each field plus one.
// RL7: PLL reference is selectable between crystal pin and on-chip clock source.
// RL8: System clock in PLL mode spans K2 VCO cycles per period.
// RL9: VCO band field picks one of three ascending bands, codes 00, 01, 10.
// RL10: Select 00 takes the system clock from the low-frequency wakeup source.
// RL11: Software writes divider and select fields so no unintended intermediate setup occurs.
// RL12: Software changes the system clock frequency only in small steps.
// RL13: Source switching never produces truncated or glitch pulses on the system clock; leaving the PLL source can cut a high pulse short.
module scg_clock_gen (
	// APB slave
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Clock sources
	input  wire logic        direct_clock_pin,
	input  wire logic        crystal_input_pin,
	input  wire logic        internal_osc_clk,
	input  wire logic        wakeup_clk,
	// Generated clock and PLL controls
	output logic             sys_clk,
	output logic             pll_enable,
	output logic      [1:0]  vco_band_select,
	output logic             pll_locked
);

	typedef enum logic [1:0] {
		ST_RUN  = 2'b01,
		ST_PARK = 2'b10
	} scg_state_t;

	function automatic logic [10:0] plus_one(input logic [9:0] f);
		plus_one = {1'b0, f} + 11'h001;
	endfunction : plus_one

	logic [1:0]                    sys_clock_source_select;
	scg_pkg::scg_pll_cfg_t         pll_cfg;
	logic [scg_pkg::PRESCALER_DIV_FIELD_W-1:0]   prescaler_div_field;
	logic [scg_pkg::IN_N-1:0]      sync_a;
	logic [scg_pkg::IN_N-1:0]      sync_b;
	logic [scg_pkg::IN_N-1:0]      sync_c;
	logic [scg_pkg::IN_N-1:0]      clk_in;
	logic [scg_pkg::IN_N-1:0]      clk_prev;
	logic                          osc_src;
	logic                          osc_prev;
	logic                          osc_rise;
	logic [9:0]                    k1_cnt;
	logic [10:0]                   k1;
	logic                          presc_clk;
	logic [scg_pkg::PLL_INPUT_DIV_FIELD_W-1:0]    p_cnt;
	logic                          ref_edge;
	logic [scg_pkg::PER_W-1:0]     per_cnt;
	logic [scg_pkg::PER_W-1:0]     per_meas;
	logic                          per_valid;
	logic [scg_pkg::ACC_W-1:0]     acc;
	logic [scg_pkg::ACC_W-1:0]     acc_sum;
	logic                          vco_tick;
	logic [scg_pkg::PLL_OUTPUT_DIV_FIELD_W-1:0]   k2_cnt;
	logic                          pll_clk;
	logic                          pll_cfg_wr;
	scg_pkg::scg_src_t             want_src;
	scg_pkg::scg_src_t             active_src;
	scg_state_t                    state;
	logic                          cand_clk;
	logic                          setup;
	logic                          wr_en;
	logic [31:0]                   next_prdata;
	logic                          next_err;

	// APB access decode
	assign setup = psel & ~penable;
	assign wr_en = psel & penable & pready & pwrite;
	assign pll_cfg_wr = wr_en & (paddr == scg_pkg::PLL_CFG_OFS);

	// Zero wait states: answer is ready in the access phase that follows setup
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			pready  <= setup;
			prdata  <= setup & ~pwrite ? next_prdata : 32'h0000_0000;
			pslverr <= setup & next_err;
		end
	end

	always_comb begin
		next_prdata = 32'h0000_0000;
		next_err    = 1'b0;
		unique case (paddr)
			scg_pkg::SYS_CFG_OFS: next_prdata[1:0] = sys_clock_source_select;
			scg_pkg::PLL_CFG_OFS: next_prdata[22:0] = pll_cfg;
			scg_pkg::PRESC_OFS:   next_prdata[9:0] = prescaler_div_field;
			scg_pkg::STATUS_OFS: begin
				next_prdata[scg_pkg::ST_ACT_LSB +: 2] = active_src;
				next_prdata[scg_pkg::ST_LOCK_POS]    = pll_locked;
				next_prdata[scg_pkg::ST_SW_POS]      = (state == ST_PARK);
				next_prdata[scg_pkg::ST_EN_POS]      = pll_enable;
			end
			default: next_err = 1'b1;
		endcase
	end

	// Configuration registers; field values take effect as written, sequencing is up to software
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sys_clock_source_select <= scg_pkg::SEL_RST;
			pll_cfg                 <= scg_pkg::PLL_CFG_RST;
			prescaler_div_field     <= scg_pkg::PRESCALER_DIV_FIELD_RST;
		end else if (wr_en) begin
			if (paddr == scg_pkg::SYS_CFG_OFS)
				sys_clock_source_select <= pwdata[1:0];
			if (pll_cfg_wr) begin
				pll_cfg.bypass  <= pwdata[scg_pkg::PLL_BYP_POS];
				pll_cfg.ref_sel <= pwdata[scg_pkg::PLL_REF_POS]; // RL7
				pll_cfg.band    <= pwdata[scg_pkg::PLL_BAND_LSB +: scg_pkg::BAND_W];
				pll_cfg.pll_input_div_field    <= pwdata[scg_pkg::PLL_PLL_INPUT_DIV_FIELD_LSB +: scg_pkg::PLL_INPUT_DIV_FIELD_W];
				pll_cfg.pll_mult_field    <= pwdata[scg_pkg::PLL_PLL_MULT_FIELD_LSB +: scg_pkg::PLL_MULT_FIELD_W];
				pll_cfg.pll_output_div_field   <= pwdata[scg_pkg::PLL_K2_LSB +: scg_pkg::PLL_OUTPUT_DIV_FIELD_W];
			end
			if (paddr == scg_pkg::PRESC_OFS)
				prescaler_div_field <= pwdata[9:0];
		end
	end

	// Three-stage sampling of the clock inputs; a level counts once stages two and three agree
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync_a <= 4'h0;
			sync_b <= 4'h0;
			sync_c <= 4'h0;
			clk_in <= 4'h0;
		end else begin
			sync_a <= {wakeup_clk, internal_osc_clk, crystal_input_pin, direct_clock_pin};
			sync_b <= sync_a;
			sync_c <= sync_b;
			for (int i = 0; i < scg_pkg::IN_N; i++)
				if (sync_b[i] == sync_c[i])
					clk_in[i] <= sync_c[i];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clk_prev <= 4'h0;
		end else begin
			clk_prev <= clk_in;
		end
	end

	// Shared reference for prescaler and PLL: crystal or on-chip source
	assign osc_src  = pll_cfg.ref_sel ? clk_in[scg_pkg::IN_INTOSC] : clk_in[scg_pkg::IN_XTAL]; // RL7
	assign osc_prev = pll_cfg.ref_sel ? clk_prev[scg_pkg::IN_INTOSC] : clk_prev[scg_pkg::IN_XTAL];
	assign osc_rise = osc_src & ~osc_prev;
	assign k1       = plus_one(prescaler_div_field);

	// Prescaler K1: high for the first half of each K1 input periods
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			k1_cnt    <= 10'h000;
			presc_clk <= 1'b0;
		end else if (prescaler_div_field == scg_pkg::PRESCALER_DIV_FIELD_RST) begin
			k1_cnt    <= 10'h000;
			presc_clk <= osc_src; // RL4
		end else if (osc_rise) begin
			if ({1'b0, k1_cnt} == k1 - 11'h001) begin // RL3
				k1_cnt    <= 10'h000;
				presc_clk <= 1'b1;
			end else begin
				k1_cnt    <= k1_cnt + 10'h001;
				presc_clk <= ({1'b0, k1_cnt} + 11'h001) < (k1 >> 1); // RL2
			end
		end
	end

	// PLL enabled only for select 10 with bypass clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pll_enable      <= 1'b0;
			vco_band_select <= scg_pkg::BAND_LOW;
		end else begin
			pll_enable <= (sys_clock_source_select == scg_pkg::SEL_OSC) & ~pll_cfg.bypass; // RL5
			// Unused code 11 falls back to the highest band
			vco_band_select <= (pll_cfg.band == 2'h3) ? scg_pkg::BAND_HIGH : pll_cfg.band; // RL9
		end
	end

	// Input divider P: one reference event per P input periods
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			p_cnt    <= 4'h0;
			ref_edge <= 1'b0;
		end else if (!pll_enable) begin
			p_cnt    <= 4'h0;
			ref_edge <= 1'b0;
		end else begin
			ref_edge <= 1'b0;
			if (osc_rise) begin
				if (p_cnt == pll_cfg.pll_input_div_field) begin // RL6
					p_cnt    <= 4'h0;
					ref_edge <= 1'b1;
				end else begin
					p_cnt <= p_cnt + 4'h1;
				end
			end
		end
	end

	// Period of the divided reference in pclk cycles; lock on two equal periods
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			per_cnt    <= 20'h0_0000;
			per_meas   <= 20'h0_0000;
			per_valid  <= 1'b0;
			pll_locked <= 1'b0;
		end else if (!pll_enable || pll_cfg_wr) begin
			per_cnt    <= 20'h0_0000;
			per_valid  <= 1'b0;
			pll_locked <= 1'b0;
		end else if (ref_edge) begin
			per_cnt    <= 20'h0_0000;
			per_meas   <= per_cnt + 20'h0_0001;
			per_valid  <= 1'b1;
			pll_locked <= per_valid & (per_meas == per_cnt + 20'h0_0001);
		end else if (per_cnt != 20'hF_FFFF) begin
			per_cnt <= per_cnt + 20'h0_0001;
		end
	end

	// VCO as a rate accumulator: 2N half-cycle ticks per divided reference period
	assign acc_sum  = acc + {12'h000, pll_cfg.pll_mult_field, 1'b0} + 21'h0_0002;
	assign vco_tick = pll_locked & (acc_sum >= {1'b0, per_meas});

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			acc <= 21'h0_0000;
		end else if (!pll_locked) begin
			acc <= 21'h0_0000;
		end else if (vco_tick) begin
			acc <= acc_sum - {1'b0, per_meas}; // RL6
		end else begin
			acc <= acc_sum;
		end
	end

	// Output divider K2: toggle every K2 ticks, so one period spans K2 VCO cycles
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			k2_cnt  <= 7'h00;
			pll_clk <= 1'b0;
		end else if (!pll_locked) begin
			k2_cnt  <= 7'h00;
			pll_clk <= 1'b0;
		end else if (vco_tick) begin
			if (k2_cnt == pll_cfg.pll_output_div_field) begin // RL8
				k2_cnt  <= 7'h00;
				pll_clk <= ~pll_clk;
			end else begin
				k2_cnt <= k2_cnt + 7'h01;
			end
		end
	end

	// Requested source; reserved select 01 behaves as wakeup
	always_comb begin
		unique case (sys_clock_source_select)
			scg_pkg::SEL_DIRECT: want_src = scg_pkg::SRC_DIRECT; // RL1
			scg_pkg::SEL_OSC:    want_src = pll_cfg.bypass ? scg_pkg::SRC_PRESC
								: scg_pkg::SRC_PLL; // RL2 RL5
			default:             want_src = scg_pkg::SRC_WAKEUP; // RL10
		endcase
	end

	always_comb begin
		unique case (active_src)
			scg_pkg::SRC_DIRECT: cand_clk = clk_in[scg_pkg::IN_DIRECT]; // RL1
			scg_pkg::SRC_PRESC:  cand_clk = presc_clk;
			scg_pkg::SRC_PLL:    cand_clk = pll_clk;
			default:             cand_clk = clk_in[scg_pkg::IN_WAKEUP]; // RL10
		endcase
	end

	// Glitch-free switch: leave old source only while low, join new one only while it is low.
	// A low phase may stretch during a switch; only a PLL high pulse can be cut short, as the PLL stops once deselected.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state      <= ST_RUN;
			active_src <= scg_pkg::SRC_WAKEUP;
			sys_clk    <= 1'b0;
		end else begin
			unique case (state)
				ST_RUN: begin
					if (want_src != active_src && !sys_clk && !cand_clk) begin // RL13
						state      <= ST_PARK;
						active_src <= want_src;
						sys_clk    <= 1'b0;
					end else begin
						sys_clk <= cand_clk;
					end
				end
				ST_PARK: begin
					sys_clk <= 1'b0;
					if (!cand_clk)
						state <= ST_RUN; // RL13
				end
				default: begin
					state   <= ST_RUN;
					sys_clk <= 1'b0;
				end
			endcase
		end
	end

endmodule : scg_clock_gen

// [bench/scg_checker.sv]
module scg_checker (
	// Bus
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// Clocks and controls
	input wire logic        sys_clk,
	input wire logic        pll_enable,
	input wire logic [1:0]  vco_band_select,
	input wire logic        pll_locked
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [1:0] sh_sel;
	logic [1:0] sh_band;
	logic       sh_byp;
	logic       want_pll;
	logic       acc_wr;

	assign acc_wr   = psel && penable && pready && pwrite;
	assign want_pll = sh_sel == 2'h2 && !sh_byp;

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	// Shadow of the fields that steer outputs
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sh_sel  <= 2'h0;
			sh_band <= 2'h0;
			sh_byp  <= 1'b1;
		end else if (acc_wr && paddr == scg_pkg::SYS_CFG_OFS) begin
			sh_sel <= pwdata[1:0];
		end else if (acc_wr && paddr == scg_pkg::PLL_CFG_OFS) begin
			sh_byp  <= pwdata[0];
			sh_band <= (pwdata[3:2] == 2'h3) ? 2'h2 : pwdata[3:2];
		end
	end

	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_pll_wr;
		acc_wr && paddr == scg_pkg::PLL_CFG_OFS;
	endsequence

	a_ready_after_setup: assert property (s_setup |=> pready)
		else $error("pready missing after setup");
	a_ready_one_cycle: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	a_err_unmapped: assert property (pready |-> pslverr == !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0C}))
		else $error("pslverr wrong for address");
	a_rdata_idle: assert property (!pready |-> prdata == 32'h0000_0000)
		else $error("prdata not zero outside access");
	a_high_whole: assert property ($rose(sys_clk) |=> sys_clk)
		else $error("sys_clk high pulse truncated");
	a_low_whole: assert property ($fell(sys_clk) |=> !sys_clk)
		else $error("sys_clk low pulse truncated");
	a_pll_enable: assert property ($stable(want_pll) |-> pll_enable == want_pll)
		else $error("pll_enable disagrees with config");
	a_band_follow: assert property ($stable(sh_band) |-> vco_band_select == sh_band)
		else $error("vco band disagrees with config");
	a_lock_drop: assert property (s_pll_wr |=> !pll_locked)
		else $error("lock kept after reconfiguration");
endmodule : scg_checker

bind scg_clock_gen scg_checker scg_checker_i (.*);

// [bench/scg_src_model.sv]
module scg_src_model #(
	parameter int DIRECT_HALF = 400,
	parameter int XTAL_HALF   = 300,
	parameter int INTOSC_HALF = 500,
	parameter int WAKEUP_HALF = 1100
) (
	// Clock sources
	output logic direct_clock_pin,
	output logic crystal_input_pin,
	output logic internal_osc_clk,
	output logic wakeup_clk
);
	timeunit 1ns;
	timeprecision 1ns;
	// Halves kept at three pclk or more so the synchroniser sees each level
	initial begin
		direct_clock_pin  = 1'b0;
		crystal_input_pin = 1'b0;
		internal_osc_clk  = 1'b0;
		wakeup_clk        = 1'b0;
	end
	always #DIRECT_HALF direct_clock_pin = ~direct_clock_pin;
	always #XTAL_HALF crystal_input_pin = ~crystal_input_pin;
	always #INTOSC_HALF internal_osc_clk = ~internal_osc_clk;
	always #WAKEUP_HALF wakeup_clk = ~wakeup_clk;
endmodule : scg_src_model

// [bench/testbench.sv]
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd, seed;
	logic        direct_clock_pin, crystal_input_pin, internal_osc_clk, wakeup_clk;
	logic        sys_clk, pll_enable, pll_locked;
	logic [1:0]  vco_band_select;
	int          num_errors, tests_run, m_sel, m_pll, m_presc;
	int          c_sel[8] = '{0, 1, 3, 2, 2, 2, 2, 2};
	int          c_pll[8] = '{1, 1, 1, 1, 3, 1, 32'h0001_0310, 32'h0001_0102};
	int          c_k1[8]  = '{0, 0, 0, 0, 2, 1023, 0, 0};
	int          c_per[8] = '{2200, 2200, 800, 600, 3000, 614400, 600, 1000};
	int          c_src[8] = '{0, 0, 3, 1, 1, 1, 2, 2};

	scg_src_model scg_src_model_i (.*);
	scg_clock_gen scg_clock_gen_i (.*);

	always #50 pclk = ~pclk;

	function automatic logic [31:0] xorshift(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction : xorshift

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask : chk

	task automatic chk_per(input string what, input int exp, input int got);
		tests_run++;
		if (got < exp - 100 || got > exp + 100) begin
			num_errors++;
			$display("unexpected %s period: expected %0d, seen %0d", what, exp, got);
		end
	endtask : chk_per

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		// Zero wait states: answer at the first access edge
		chk("access cycles", 32'h1, n);
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
		if (a == 8'h00) m_sel = d & 3;
		if (a == 8'h04) m_pll = d & 32'h007F_FFFF;
		if (a == 8'h08) m_presc = d & 32'h0000_03FF;
	endtask : wr

	task automatic rdchk(input logic [7:0] a);
		int e;
		e = (a == 8'h00) ? m_sel : (a == 8'h04) ? m_pll : (a == 8'h08) ? m_presc : 0;
		apb(1'b0, a, 32'h0000_0000);
		chk("read data", e, rd);
		chk("slave error", !(a inside {8'h00, 8'h04, 8'h08, 8'h0C}), {31'h0, err});
	endtask : rdchk

	task automatic measure(input string what, input int exp);
		time t0;
		repeat (2) @(posedge sys_clk);
		t0 = $time;
		repeat (2) @(posedge sys_clk);
		chk_per(what, exp, int'(($time - t0) / 2));
	endtask : measure

	task automatic wrap_up;
		$display("comparisons %0d, mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : wrap_up

	initial begin
		#8_000_000;
		num_errors++;
		wrap_up();
	end

	initial begin
		{pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		{num_errors, tests_run, m_sel, m_presc} = '0;
		m_pll = 1;
		seed = 32'h0001_4CCA;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		foreach (c_sel[i]) rdchk(8'h04 * i[7:0] + 8'h02 * (i[7:0] / 5));
		$display("test reset values done");
		for (int i = 0; i < 6; i++) begin
			seed = xorshift(seed);
			// Select kept to codes 00 and 01, off the oscillator and direct paths, so status still reads zero
			wr(8'h04 * i[7:0] % 8'h14, (i % 5 == 0) ? seed & 32'hFFFF_FFFD : seed);
			rdchk(8'h04 * i[7:0] % 8'h14);
		end
		$display("test register access done");
		foreach (c_sel[i]) begin
			wr(8'h00, 0);
			wr(8'h04, c_pll[i]);
			wr(8'h08, c_k1[i]);
			wr(8'h00, c_sel[i]);
			measure("sys_clk", c_per[i]);
			apb(1'b0, 8'h0C, 32'h0000_0000);
			chk("active source", c_src[i], {30'h0, rd[1:0]});
			chk("pll enable", c_src[i] == 2, {31'h0, pll_enable});
			if (c_src[i] == 2) chk("pll lock", 32'h1, {31'h0, pll_locked});
		end
		$display("test clock sources done");
		for (int b = 0; b < 4; b++) begin
			wr(8'h04, (b << 2) | 1);
			repeat (2) @(posedge pclk);
			chk("vco band", (b == 3) ? 2 : b, {30'h0, vco_band_select});
		end
		$display("test vco bands done");
		wrap_up();
	end
endmodule : testbench
